// File: tmr_pkg.sv
package tmr_pkg;

    // ****************************************
    // Register map.
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_GP_LOW = 8'h08;
    localparam logic [7:0] OFF_GP_HIGH = 8'h0C;
    localparam logic [7:0] OFF_SPEECH0 = 8'h10;
    localparam logic [7:0] SPEECH_STRIDE = 8'h04;
    localparam logic [7:0] OFF_MELODY = 8'h20;
    localparam logic [7:0] OFF_CLOCK = 8'h24;
    localparam logic [7:0] OFF_RTC = 8'h28;
    localparam logic [7:0] OFF_ALARM = 8'h2C;
    localparam logic [7:0] OFF_NSC = 8'h30;
    localparam logic [7:0] OFF_TICKSEL = 8'h34;

    // ****************************************
    // Sizes and flag positions.
    // ****************************************
    localparam int unsigned SPEECH_N = 4;
    localparam int unsigned TIMER_N = 8;
    localparam int unsigned TICK_N = 4;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned FLAG_N = 14;
    localparam int unsigned FL_GP_LOW = 0;
    localparam int unsigned FL_GP_HIGH = 1;
    localparam int unsigned FL_SPEECH0 = 2;
    localparam int unsigned FL_MELODY = 6;
    localparam int unsigned FL_CLOCK = 7;
    localparam int unsigned FL_ALARM = 8;
    localparam int unsigned FL_SEC = 9;
    localparam int unsigned FL_MIN = 10;
    localparam int unsigned FL_HOUR = 11;
    localparam int unsigned FL_DAY = 12;
    localparam int unsigned FL_WDOG = 13;

    // Tick select slots, one per timer.
    localparam int unsigned TS_GP = 0;
    localparam int unsigned TS_SPEECH0 = 1;
    localparam int unsigned TS_MELODY = 5;
    localparam int unsigned TS_CLOCK = 6;
    localparam int unsigned TS_NSC = 7;

    // ****************************************
    // Counting limits and modes.
    // ****************************************
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_NEAR_MAX = 8'hFE;
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] MIN_MAX = 8'h3B;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] LFSR_TAPS = 8'hB8;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    localparam logic [1:0] GP_SPLIT = 2'h0;
    localparam logic [1:0] GP_CASCADE = 2'h1;
    localparam logic [1:0] GP_RELOAD = 2'h2;
    localparam logic [1:0] NSC_OFF = 2'h0;
    localparam logic [1:0] NSC_WATCHDOG = 2'h1;
    localparam logic [1:0] NSC_RANDOM = 2'h2;

    typedef struct packed {
        logic clock_run;
        logic [3:0] speech_run;
        logic [1:0] nsc_mode;
        logic alarm_arm_bit;
        logic realtime_run_enable;
        logic [1:0] gp_mode;
        logic gp_run_enable;
    } tmr_ctrl_t;

    localparam int unsigned CTRL_W = 12;
    localparam logic [11:0] CTRL_RESET = 12'h000;

    typedef struct packed {
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } tmr_time_t;

    typedef enum logic [1:0] {
        MEL_IDLE = 2'b01,
        MEL_RUN = 2'b10
    } tmr_mel_state_t;

endpackage : tmr_pkg

// File: tmr_timer_set.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Two 8-bit up counters, low and high, chain into one 16-bit timer.
// - Each general timer sets its own overflow flag on a tick at FFH, wrapping to zero or, for low in reload mode, reloading.
// - Auto-reload: low wrap reloads low counter from high register, high unchanged.
// - General timers count only while their run-enable bit is 1; the high counter stops in reload mode.
// - Four speech timers plus melody, clock, real-time and watchdog timers.
// - Speech timer is 8-bit up counter setting its flag on wrap.
// - On speech wrap the counter reloads from its untouched reload register.
// - Melody timer starts counting up right after software loads it.
// - Melody counter sets its flag on a tick at FEH or FFH and stops at FFH without reload.
// - Clock timer counts up, flags and reloads from its reload register.
// - Writing the clock reload register also loads the clock counter.
// - Enabled real-time clock counts seconds and carries to minute and hour; day only clears on hour wrap.
// - After 17h:3Bh:3Bh the next tick clears all time registers.
// - Armed alarm match sets the alarm flag and clears the arm bit.
// - Real-time clock gives second, minute, hour and day events.
// - Non-sequential 8-bit counter works as watchdog or random generator.
// - In random mode it runs every clock, repeating after fixed clocks.
// - Speech and second are level 2, melody level 3, rest level 4 except watchdog, which has no level.
module tmr_timer_set #(
    parameter logic [7:0] WDOG_LAST = 8'h80
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tmr_pkg::TICK_N-1:0] tick_src,
    output logic irq_level2,
    output logic irq_level3,
    output logic irq_level4,
    output logic [tmr_pkg::FLAG_N-1:0] event_flags,
    output logic watchdog_expire,
    output logic [7:0] random_value
);

    // ****************************************
    // Bus decode.
    // ****************************************
    logic wr;
    logic setup;
    logic hit;
    logic [31:0] rd_data;
    tmr_pkg::tmr_ctrl_t ctrl;
    logic [tmr_pkg::TIMER_N*tmr_pkg::SEL_W-1:0] ticksel;
    logic [tmr_pkg::TIMER_N-1:0] tick;
    logic [tmr_pkg::FLAG_N-1:0] flag_set;
    logic [tmr_pkg::FLAG_N-1:0] flag_clr;

    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ****************************************
    // Tick selection.
    // ****************************************
    genvar j;
    generate
        for (j = 0; j < tmr_pkg::TIMER_N; j++)
        begin : g_tick
            assign tick[j] = tick_src[ticksel[j*tmr_pkg::SEL_W +: tmr_pkg::SEL_W]];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ticksel <= '0;
        else if (wr && paddr == tmr_pkg::OFF_TICKSEL)
            ticksel <= pwdata[tmr_pkg::TIMER_N*tmr_pkg::SEL_W-1:0];
    end

    // ****************************************
    // General purpose timers.
    // ****************************************
    logic [7:0] gp_low_counter;
    logic [7:0] gp_high_counter_reload;
    logic gp_tick;
    logic gp_low_wrap;
    logic gp_high_step;

    assign gp_tick = tick[tmr_pkg::TS_GP] && ctrl.gp_run_enable;
    assign gp_low_wrap = gp_tick && gp_low_counter == tmr_pkg::CNT_MAX;
    assign gp_high_step = (ctrl.gp_mode == tmr_pkg::GP_CASCADE) ? gp_low_wrap :
                          (ctrl.gp_mode == tmr_pkg::GP_SPLIT) ? gp_tick : 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gp_low_counter <= '0;
        else if (wr && paddr == tmr_pkg::OFF_GP_LOW)
            gp_low_counter <= pwdata[7:0];
        else if (gp_low_wrap && ctrl.gp_mode == tmr_pkg::GP_RELOAD)
            gp_low_counter <= gp_high_counter_reload;
        else if (gp_tick)
            gp_low_counter <= gp_low_counter + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gp_high_counter_reload <= '0;
        else if (wr && paddr == tmr_pkg::OFF_GP_HIGH)
            gp_high_counter_reload <= pwdata[7:0];
        else if (gp_high_step)
            gp_high_counter_reload <= gp_high_counter_reload + 8'h01;
    end

    assign flag_set[tmr_pkg::FL_GP_LOW] = gp_low_wrap;
    assign flag_set[tmr_pkg::FL_GP_HIGH] = gp_high_step && gp_high_counter_reload == tmr_pkg::CNT_MAX;

    // ****************************************
    // Speech timers.
    // ****************************************
    logic [7:0] speech_count [tmr_pkg::SPEECH_N];
    logic [7:0] speech_reload_value [tmr_pkg::SPEECH_N];

    genvar i;
    generate
        for (i = 0; i < tmr_pkg::SPEECH_N; i++)
        begin : g_speech
            logic sp_tick;
            logic sp_wrap;
            logic [7:0] sp_off;

            assign sp_off = tmr_pkg::OFF_SPEECH0 + 8'(tmr_pkg::SPEECH_STRIDE * i);
            assign sp_tick = tick[tmr_pkg::TS_SPEECH0 + i] && ctrl.speech_run[i];
            assign sp_wrap = sp_tick && speech_count[i] == tmr_pkg::CNT_MAX;
            assign flag_set[tmr_pkg::FL_SPEECH0 + i] = sp_wrap;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    speech_reload_value[i] <= '0;
                else if (wr && paddr == sp_off)
                    speech_reload_value[i] <= pwdata[7:0];
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    speech_count[i] <= '0;
                else if (sp_wrap)
                    speech_count[i] <= speech_reload_value[i];
                else if (sp_tick)
                    speech_count[i] <= speech_count[i] + 8'h01;
            end
        end
    endgenerate

    // ****************************************
    // Melody timer.
    // ****************************************
    tmr_pkg::tmr_mel_state_t mel_state;
    logic [7:0] melody_count;
    logic mel_tick;
    logic mel_done;

    assign mel_tick = tick[tmr_pkg::TS_MELODY] && mel_state == tmr_pkg::MEL_RUN;
    assign mel_done = mel_tick && melody_count >= tmr_pkg::CNT_NEAR_MAX;
    assign flag_set[tmr_pkg::FL_MELODY] = mel_done;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mel_state <= tmr_pkg::MEL_IDLE;
        else if (wr && paddr == tmr_pkg::OFF_MELODY)
            mel_state <= tmr_pkg::MEL_RUN;
        else
        begin
            unique case (mel_state)
                tmr_pkg::MEL_IDLE: mel_state <= tmr_pkg::MEL_IDLE;
                tmr_pkg::MEL_RUN: mel_state <= mel_done ? tmr_pkg::MEL_IDLE : tmr_pkg::MEL_RUN;
                default: mel_state <= tmr_pkg::MEL_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            melody_count <= '0;
        else if (wr && paddr == tmr_pkg::OFF_MELODY)
            melody_count <= pwdata[7:0];
        else if (mel_tick && melody_count != tmr_pkg::CNT_MAX)
            melody_count <= melody_count + 8'h01;
    end

    // ****************************************
    // Clock timer.
    // ****************************************
    logic [7:0] clock_count;
    logic [7:0] clock_timer_reload_value;
    logic ct_tick;
    logic ct_wrap;

    assign ct_tick = tick[tmr_pkg::TS_CLOCK] && ctrl.clock_run;
    assign ct_wrap = ct_tick && clock_count == tmr_pkg::CNT_MAX;
    assign flag_set[tmr_pkg::FL_CLOCK] = ct_wrap;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_timer_reload_value <= '0;
        else if (wr && paddr == tmr_pkg::OFF_CLOCK)
            clock_timer_reload_value <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_count <= '0;
        else if (wr && paddr == tmr_pkg::OFF_CLOCK)
            clock_count <= pwdata[7:0];
        else if (ct_wrap)
            clock_count <= clock_timer_reload_value;
        else if (ct_tick)
            clock_count <= clock_count + 8'h01;
    end

    // ****************************************
    // Real-time clock and alarm.
    // ****************************************
    tmr_pkg::tmr_time_t rtc;
    tmr_pkg::tmr_time_t alarm;
    logic rtc_tick;
    logic sec_roll;
    logic min_roll;
    logic hour_roll;
    logic alarm_hit;

    assign rtc_tick = ct_wrap && ctrl.realtime_run_enable;
    assign sec_roll = rtc.second == tmr_pkg::SEC_MAX;
    assign min_roll = rtc.minute == tmr_pkg::MIN_MAX;
    assign hour_roll = rtc.hour == tmr_pkg::HOUR_MAX;
    assign flag_set[tmr_pkg::FL_SEC] = rtc_tick;
    assign flag_set[tmr_pkg::FL_MIN] = rtc_tick && sec_roll;
    assign flag_set[tmr_pkg::FL_HOUR] = rtc_tick && sec_roll && min_roll;
    assign flag_set[tmr_pkg::FL_DAY] = rtc_tick && sec_roll && min_roll && hour_roll;
    assign alarm_hit = ctrl.alarm_arm_bit && rtc.hour == alarm.hour
                       && rtc.minute == alarm.minute && rtc.second == alarm.second;
    assign flag_set[tmr_pkg::FL_ALARM] = alarm_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rtc <= '0;
        else if (wr && paddr == tmr_pkg::OFF_RTC)
            rtc <= pwdata;
        else if (rtc_tick)
        begin
            if (!sec_roll)
                rtc.second <= rtc.second + 8'h01;
            else
            begin
                rtc.second <= tmr_pkg::ZERO8;
                if (!min_roll)
                    rtc.minute <= rtc.minute + 8'h01;
                else
                begin
                    rtc.minute <= tmr_pkg::ZERO8;
                    if (!hour_roll)
                        rtc.hour <= rtc.hour + 8'h01;
                    else
                    begin
                        rtc.hour <= tmr_pkg::ZERO8;
                        rtc.day <= tmr_pkg::ZERO8;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm <= '0;
        else if (wr && paddr == tmr_pkg::OFF_ALARM)
            alarm <= pwdata;
    end

    // ****************************************
    // Control register.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= tmr_pkg::CTRL_RESET;
        else if (wr && paddr == tmr_pkg::OFF_CTRL)
            ctrl <= pwdata[tmr_pkg::CTRL_W-1:0];
        else if (alarm_hit)
            ctrl.alarm_arm_bit <= 1'b0;
    end

    // ****************************************
    // Non-sequential counter.
    // ****************************************
    logic [7:0] nsc;
    logic [7:0] next_nsc;
    logic nsc_step;
    logic wdog_hit;
    logic wdog_kick;

    assign next_nsc = {1'b0, nsc[7:1]} ^ (nsc[0] ? tmr_pkg::LFSR_TAPS : tmr_pkg::ZERO8);
    assign nsc_step = (ctrl.nsc_mode == tmr_pkg::NSC_RANDOM) ||
                      (ctrl.nsc_mode == tmr_pkg::NSC_WATCHDOG && tick[tmr_pkg::TS_NSC]);
    assign wdog_hit = ctrl.nsc_mode == tmr_pkg::NSC_WATCHDOG && tick[tmr_pkg::TS_NSC] && nsc == WDOG_LAST;
    assign wdog_kick = wr && paddr == tmr_pkg::OFF_NSC;
    assign flag_set[tmr_pkg::FL_WDOG] = wdog_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nsc <= tmr_pkg::LFSR_SEED;
        else if (wdog_kick || wdog_hit)
            nsc <= tmr_pkg::LFSR_SEED;
        else if (nsc_step)
            nsc <= next_nsc;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            watchdog_expire <= 1'b0;
        else
            watchdog_expire <= wdog_hit;
    end

    assign random_value = nsc;

    // ****************************************
    // Flags and priority requests.
    // ****************************************
    assign flag_clr = (wr && paddr == tmr_pkg::OFF_FLAGS) ? pwdata[tmr_pkg::FLAG_N-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_flags <= '0;
        else
            event_flags <= (event_flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_level2 <= 1'b0;
            irq_level3 <= 1'b0;
            irq_level4 <= 1'b0;
        end
        else
        begin
            irq_level2 <= |event_flags[tmr_pkg::FL_SPEECH0 +: tmr_pkg::SPEECH_N]
                          || event_flags[tmr_pkg::FL_SEC];
            irq_level3 <= event_flags[tmr_pkg::FL_MELODY];
            irq_level4 <= event_flags[tmr_pkg::FL_GP_LOW] || event_flags[tmr_pkg::FL_GP_HIGH]
                          || event_flags[tmr_pkg::FL_CLOCK] || event_flags[tmr_pkg::FL_ALARM]
                          || event_flags[tmr_pkg::FL_MIN] || event_flags[tmr_pkg::FL_HOUR]
                          || event_flags[tmr_pkg::FL_DAY];
        end
    end

    // ****************************************
    // Read data.
    // ****************************************
    always_comb
    begin
        rd_data = '0;
        hit = 1'b1;
        unique case (paddr)
            tmr_pkg::OFF_CTRL: rd_data[tmr_pkg::CTRL_W-1:0] = ctrl;
            tmr_pkg::OFF_FLAGS: rd_data[tmr_pkg::FLAG_N-1:0] = event_flags;
            tmr_pkg::OFF_GP_LOW: rd_data[7:0] = gp_low_counter;
            tmr_pkg::OFF_GP_HIGH: rd_data[7:0] = gp_high_counter_reload;
            tmr_pkg::OFF_MELODY: rd_data[7:0] = melody_count;
            tmr_pkg::OFF_CLOCK: rd_data[15:0] = {clock_count, clock_timer_reload_value};
            tmr_pkg::OFF_RTC: rd_data = rtc;
            tmr_pkg::OFF_ALARM: rd_data = alarm;
            tmr_pkg::OFF_NSC: rd_data[7:0] = nsc;
            tmr_pkg::OFF_TICKSEL: rd_data[tmr_pkg::TIMER_N*tmr_pkg::SEL_W-1:0] = ticksel;
            default:
            begin
                hit = 1'b0;
                for (int k = 0; k < tmr_pkg::SPEECH_N; k++)
                begin
                    if (paddr == tmr_pkg::OFF_SPEECH0 + 8'(tmr_pkg::SPEECH_STRIDE * k))
                    begin
                        hit = 1'b1;
                        rd_data[15:0] = {speech_count[k], speech_reload_value[k]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup)
            prdata <= rd_data;
    end

endmodule : tmr_timer_set

// File: tmr_timer_set_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the timer set.
// ****************************************
module tmr_timer_set_monitor #(
    parameter logic [7:0] WDOG_LAST = 8'h80
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_level2,
    input wire logic irq_level3,
    input wire logic irq_level4,
    input wire logic [tmr_pkg::FLAG_N-1:0] event_flags,
    input wire logic watchdog_expire
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_pready_high:
        assert property (pready) else $error("pready low");
    a_unmapped_refused:
        assert property (psel && penable && paddr > tmr_pkg::OFF_TICKSEL |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_prdata_holds:
        assert property (psel && penable |=> $stable(prdata)) else $error("read data moved");
    a_irq_two:
        assert property (irq_level2 == $past(|{event_flags[5:2], event_flags[9]})) else $error("level 2 wrong");
    a_irq_three:
        assert property (irq_level3 == $past(event_flags[6])) else $error("level 3 wrong");
    a_irq_four:
        assert property (|{event_flags[12:10], event_flags[8:7], event_flags[1:0]} |=> irq_level4)
        else $error("level 4 missing");
    a_flag_sticky:
        assert property (|($past(event_flags) & ~event_flags)
            |-> $past(psel && penable && pwrite && paddr == tmr_pkg::OFF_FLAGS)) else $error("flag lost");
    a_day_carries:
        assert property ($rose(event_flags[12]) |-> &event_flags[11:9]) else $error("day wrap without carries");
    a_wdog_flagged:
        assert property (watchdog_expire |-> event_flags[13]) else $error("expiry without flag");
endmodule : tmr_timer_set_monitor

bind tmr_timer_set tmr_timer_set_monitor #(.WDOG_LAST(WDOG_LAST)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_level2(irq_level2), .irq_level3(irq_level3), .irq_level4(irq_level4),
    .event_flags(event_flags), .watchdog_expire(watchdog_expire));

// File: tb.sv
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
    logic irq2, irq3, irq4, wdog;
    logic [7:0] paddr;
    logic [7:0] rnd;
    logic [7:0] prev;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] tick_src;
    logic [13:0] flags;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    always #50 pclk = ~pclk;

    tmr_timer_set DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_src(tick_src), .irq_level2(irq2), .irq_level3(irq3), .irq_level4(irq4),
        .event_flags(flags), .watchdog_expire(wdog), .random_value(rnd));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        chk("slverr", {31'h0, a > 8'h34}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(what, exp, rd);
    endtask : rdc

    task automatic fl(input string what, input logic [31:0] exp);
        rdc(what, tmr_pkg::OFF_FLAGS, exp);
    endtask : fl

    task automatic clr();
        wr(tmr_pkg::OFF_CTRL, 32'h0);
        wr(tmr_pkg::OFF_FLAGS, 32'h3FFF);
    endtask : clr

    task automatic tick(input int n, input int idx);
        repeat (n)
        begin
            @(posedge pclk);
            tick_src <= 4'h1 << idx;
            @(posedge pclk);
            tick_src <= 4'h0;
        end
    endtask : tick

    task automatic t_regs();
        rdc("ctrl_reset", tmr_pkg::OFF_CTRL, 32'h0);
        fl("flags_reset", 32'h0);
        wr(8'h38, 32'hFFFFFFFF);
        rdc("unmapped", 8'h38, 32'h0);
        wr(tmr_pkg::OFF_TICKSEL, 32'h3954);
        rdc("ticksel", tmr_pkg::OFF_TICKSEL, 32'h3954);
    endtask : t_regs

    task automatic t_gp();
        wr(tmr_pkg::OFF_GP_HIGH, 32'hF0);
        wr(tmr_pkg::OFF_GP_LOW, 32'hFE);
        wr(tmr_pkg::OFF_CTRL, 32'h5);
        tick(2, 0);
        fl("gp_flag", 32'h1);
        chk("irq_level4", 32'h1, {31'h0, irq4});
        rdc("gp_reload", tmr_pkg::OFF_GP_LOW, 32'hF0);
        rdc("gp_high_kept", tmr_pkg::OFF_GP_HIGH, 32'hF0);
        clr();
        fl("flag_clear", 32'h0);
        wr(tmr_pkg::OFF_GP_HIGH, 32'h0);
        wr(tmr_pkg::OFF_GP_LOW, 32'hFF);
        wr(tmr_pkg::OFF_CTRL, 32'h3);
        tick(1, 0);
        rdc("casc_high", tmr_pkg::OFF_GP_HIGH, 32'h1);
        rdc("casc_low", tmr_pkg::OFF_GP_LOW, 32'h0);
        fl("casc_flag", 32'h1);
        clr();
    endtask : t_gp

    task automatic t_speech();
        wr(tmr_pkg::OFF_SPEECH0, 32'hFE);
        wr(tmr_pkg::OFF_CTRL, 32'h80);
        tick(256, 1);
        rdc("speech", tmr_pkg::OFF_SPEECH0, 32'hFEFE);
        fl("speech_flag", 32'h4);
        chk("irq_level2", 32'h1, {31'h0, irq2});
        clr();
    endtask : t_speech

    task automatic t_melody();
        wr(tmr_pkg::OFF_MELODY, 32'hFD);
        tick(4, 2);
        rdc("melody", tmr_pkg::OFF_MELODY, 32'hFF);
        fl("melody_flag", 32'h40);
        chk("irq_level3", 32'h1, {31'h0, irq3});
        clr();
    endtask : t_melody

    task automatic t_clock();
        wr(tmr_pkg::OFF_CLOCK, 32'hFE);
        rdc("clk_load", tmr_pkg::OFF_CLOCK, 32'hFEFE);
        wr(tmr_pkg::OFF_CTRL, 32'h800);
        tick(2, 3);
        rdc("clk_reload", tmr_pkg::OFF_CLOCK, 32'hFEFE);
        fl("clk_flag", 32'h80);
        clr();
    endtask : t_clock

    task automatic t_rtc();
        wr(tmr_pkg::OFF_RTC, 32'h00173B3B);
        wr(tmr_pkg::OFF_CLOCK, 32'hFF);
        wr(tmr_pkg::OFF_ALARM, 32'h1);
        wr(tmr_pkg::OFF_CTRL, 32'h818);
        tick(1, 3);
        rdc("rtc_wrap", tmr_pkg::OFF_RTC, 32'h0);
        fl("rtc_events", 32'h1E80);
        tick(1, 3);
        rdc("rtc_count", tmr_pkg::OFF_RTC, 32'h1);
        fl("alarm_flag", 32'h1F80);
        rdc("alarm_disarm", tmr_pkg::OFF_CTRL, 32'h808);
        clr();
    endtask : t_rtc

    task automatic t_nsc();
        wr(tmr_pkg::OFF_CTRL, 32'h20);
        for (int i = 0; i < 300 && flags[13] !== 1'b1; i++)
        begin
            tick(1, 0);
            @(negedge pclk);
        end
        chk("wdog_flag", 32'h1, {31'h0, flags[13]});
        wr(tmr_pkg::OFF_CTRL, 32'h40);
        @(negedge pclk);
        prev = rnd;
        @(negedge pclk);
        chk("rnd_step", 32'h1, {31'h0, rnd !== prev});
        clr();
    endtask : t_nsc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tick_src = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gp();
        t_speech();
        t_melody();
        t_clock();
        t_rtc();
        t_nsc();
        print_verdict();
    end
endmodule : tb
